// ==== include/asir_consts.svh ====
// Constants for the accelerometer sample and interrupt status register bank.
// Assumes inclusion by the bank module and its package users only.
`ifndef ASIR_CONSTS_SVH
`define ASIR_CONSTS_SVH
// Register offsets
`define ASIR_OFS_STATUS 8'h00
`define ASIR_OFS_X_HIGH 8'h01
`define ASIR_OFS_X_LOW 8'h02
`define ASIR_OFS_Y_HIGH 8'h03
`define ASIR_OFS_Y_LOW 8'h04
`define ASIR_OFS_Z_HIGH 8'h05
`define ASIR_OFS_Z_LOW 8'h06
`define ASIR_OFS_MODE 8'h0B
`define ASIR_OFS_CAUSE 8'h0C
// Interrupt cause bit positions
`define ASIR_BIT_SLEEP_WAKE 7
`define ASIR_BIT_TRANSIENT 5
`define ASIR_BIT_ORIENT 4
`define ASIR_BIT_TAP 3
`define ASIR_BIT_FALL 2
`define ASIR_BIT_READY 0
// Status register positions
`define ASIR_BIT_ALL_OW 7
`define ASIR_BIT_ALL_NEW 3
// Mode report codes and reset values
`define ASIR_MODE_STANDBY 2'h0
`define ASIR_MODE_WAKE 2'h1
`define ASIR_MODE_SLEEP 2'h2
`define ASIR_RST_BYTE 8'h00
`define ASIR_RST_SAMPLE 12'h000
`endif

// ==== include/asir_pkg.sv ====
// Types shared by the accelerometer register bank.
// Assumes the constants header is on the include path.
package asir_pkg;
    // Operating mode of the device
    typedef enum logic [1:0] {ASIR_STANDBY, ASIR_WAKE, ASIR_SLEEP} asir_mode_type;
    // Bus operation forwarded from the link side
    typedef enum logic [1:0] {ASIR_OP_LOAD, ASIR_OP_READ, ASIR_OP_STOP} asir_op_type;
endpackage

// ==== hdl/asir_regs.sv ====
// Sample byte registers, mode report and interrupt cause summary.
// Assumes a serial protocol engine on link_clk issuing load/read/stop strobes,
// and detection engines on sys_clk supplying samples, event levels and reads.
`timescale 1ns/1ps
`include "asir_consts.svh"

module asir_regs (
    input wire logic sys_clk, // System clock, 20 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic link_clk, // Serial link clock
    input wire logic link_rst, // Link-domain synchronous reset
    input wire logic cmd_load, // Pulse: address phase done
    input wire logic [7:0] cmd_addr, // Register address with cmd_load
    input wire logic cmd_read, // Pulse: host wants next byte
    input wire logic cmd_stop, // Pulse: stop condition seen
    output logic cmd_busy, // Command in flight, strobes ignored
    output logic rd_valid, // Pulse: rd_data holds a read byte
    output logic [7:0] rd_data, // Read byte
    input wire logic sample_valid, // Pulse: new sample on axis inputs
    input wire logic [11:0] x_in, // X sample
    input wire logic [11:0] y_in, // Y sample
    input wire logic [11:0] z_in, // Z sample
    input wire logic [2:0] axis_en, // Enabled axes, bit0 X
    input wire logic fast_read, // Fast-read control bit
    input wire logic active, // Active (not standby) control bit
    input wire logic sleep_en, // Auto-sleep enable
    input wire logic [7:0] idle_timeout_limit, // Idle ticks before sleep
    input wire logic idle_tick, // Pulse: one idle count period
    input wire logic [3:0] wake_sel, // Wake sources: trans,orient,tap,fall
    input wire logic [4:0] int_en, // Enables: trans,orient,tap,fall,ready
    input wire logic transient_ea, // Transient event_active_flag
    input wire logic orientation_changed_flag, // Orientation change
    input wire logic tap_ea, // Tap event_active_flag
    input wire logic fall_ea, // Fall/motion event_active_flag
    input wire logic transient_source_rd, // Pulse: transient_source_reg read
    input wire logic orientation_status_rd, // Pulse: orientation_status_reg read
    input wire logic tap_source_rd, // Pulse: tap_source_reg read
    input wire logic fall_motion_source_rd, // Pulse: fall_motion_source_reg read
    output logic [1:0] operating_mode, // Current mode code
    output logic low_rate_sel, // High in sleep: use low output_sample_rate
    output logic [7:0] interrupt_cause // Live cause summary
);
    import asir_pkg::*;

    // ****************************************************************
    // Link domain: command capture and answer
    // ****************************************************************
    typedef struct packed {
        logic req_tgl;
        asir_op_type op;
        logic [7:0] addr;
        logic busy;
        logic ack_s1;
        logic ack_s2;
        logic ack_s3;
        logic [7:0] data;
        logic valid;
    } asir_link_type;

    // ****************************************************************
    // System domain state
    // ****************************************************************
    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic ack_tgl;
        logic [7:0] rdata;
        logic [7:0] ptr;
        logic low_ok;
        logic [7:0] low_addr;
        logic [3:0] held_low;
        logic [11:0] xs;
        logic [11:0] ys;
        logic [11:0] zs;
        logic [2:0] dr;
        logic [2:0] ow;
        asir_mode_type mode;
        logic [7:0] idle_cnt;
        logic [7:0] cause;
        logic [4:0] prev_lvl;
    } asir_sys_type;

    asir_link_type l_q, l_d;
    asir_sys_type s_q, s_d;
    logic req_edge;
    logic do_read;
    logic hi_read_x;
    logic to_sleep;
    logic to_wake;
    logic [4:0] lvl;
    logic [4:0] rise;

    // Link side accepts one command at a time; the answer returns by toggle
    always_comb begin
        l_d = l_q;
        l_d.ack_s1 = s_q.ack_tgl;
        l_d.ack_s2 = l_q.ack_s1;
        l_d.ack_s3 = l_q.ack_s2;
        l_d.valid = 1'b0;
        if (l_q.busy && (l_q.ack_s2 != l_q.ack_s3)) begin
            // Answer data stays frozen until next request, so safe to take
            l_d.busy = 1'b0;
            l_d.data = s_q.rdata;
            l_d.valid = (l_q.op == ASIR_OP_READ);
        end else if (!l_q.busy && (cmd_load || cmd_read || cmd_stop)) begin
            l_d.busy = 1'b1;
            l_d.req_tgl = ~l_q.req_tgl;
            // Stop has priority so a dropped pointer is never reused
            if (cmd_stop) begin
                l_d.op = ASIR_OP_STOP;
            end else if (cmd_load) begin
                l_d.op = ASIR_OP_LOAD;
                l_d.addr = cmd_addr;
            end else begin
                l_d.op = ASIR_OP_READ;
            end
        end
    end

    // Link registers
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    assign cmd_busy = l_q.busy;
    assign rd_valid = l_q.valid;
    assign rd_data = l_q.data;

    // ****************************************************************
    // System domain: register reads, flags and mode
    // ****************************************************************
    assign req_edge = s_q.req_s2 ^ s_q.req_s3;
    assign do_read = req_edge && (l_q.op == ASIR_OP_READ);
    assign hi_read_x = do_read && (s_q.ptr == `ASIR_OFS_X_HIGH);
    assign lvl = {transient_ea & int_en[4], orientation_changed_flag & int_en[3],
                  tap_ea & int_en[2], fall_ea & int_en[1],
                  (|(s_q.dr & axis_en) | |(s_q.ow & axis_en)) & int_en[0]};
    assign rise = lvl & ~s_q.prev_lvl;
    assign to_sleep = (s_q.mode == ASIR_WAKE) && sleep_en && idle_tick
        && (s_q.idle_cnt == idle_timeout_limit) && (rise[4:1] == 4'h0);
    assign to_wake = (s_q.mode == ASIR_SLEEP) && |(rise[4:1] & wake_sel);

    always_comb begin
        logic [2:0] hi_rd;
        logic [7:0] byte_v;
        hi_rd = 3'h0;
        byte_v = `ASIR_RST_BYTE;
        s_d = s_q;
        s_d.req_s1 = l_q.req_tgl;
        s_d.req_s2 = s_q.req_s1;
        s_d.req_s3 = s_q.req_s2;
        s_d.prev_lvl = lvl;
        if (req_edge) begin
            s_d.ack_tgl = ~s_q.ack_tgl;
            s_d.rdata = `ASIR_RST_BYTE;
            unique case (l_q.op)
                ASIR_OP_LOAD: begin
                    s_d.ptr = l_q.addr;
                    s_d.low_ok = 1'b0;
                end
                ASIR_OP_STOP: begin
                    s_d.ptr = `ASIR_OFS_STATUS;
                    s_d.low_ok = 1'b0;
                end
                ASIR_OP_READ: begin
                    s_d.low_ok = 1'b0;
                    // High byte read freezes the low nibble of the same sample
                    unique case (s_q.ptr)
                        `ASIR_OFS_STATUS: begin
                            byte_v = {|(s_q.ow & axis_en), s_q.ow,
                                      |(s_q.dr & axis_en), s_q.dr};
                        end
                        `ASIR_OFS_X_HIGH: begin
                            byte_v = s_q.xs[11:4];
                            s_d.held_low = s_q.xs[3:0];
                            hi_rd[0] = 1'b1;
                        end
                        `ASIR_OFS_Y_HIGH: begin
                            byte_v = s_q.ys[11:4];
                            s_d.held_low = s_q.ys[3:0];
                            hi_rd[1] = 1'b1;
                        end
                        `ASIR_OFS_Z_HIGH: begin
                            byte_v = s_q.zs[11:4];
                            s_d.held_low = s_q.zs[3:0];
                            hi_rd[2] = 1'b1;
                        end
                        `ASIR_OFS_X_LOW, `ASIR_OFS_Y_LOW, `ASIR_OFS_Z_LOW: begin
                            // Random low reads give zero: no frozen copy to show
                            if (s_q.low_ok && s_q.low_addr == s_q.ptr) begin
                                byte_v = {s_q.held_low, 4'h0};
                            end
                        end
                        `ASIR_OFS_MODE: begin
                            byte_v = {6'h00, operating_mode};
                        end
                        `ASIR_OFS_CAUSE: begin
                            byte_v = s_q.cause;
                        end
                        default: begin
                            byte_v = `ASIR_RST_BYTE;
                        end
                    endcase
                    s_d.rdata = byte_v;
                    if (|hi_rd) begin
                        s_d.low_ok = 1'b1;
                        s_d.low_addr = s_q.ptr + 8'h01;
                    end
                    // Burst pointer walk; fast read skips the low bytes
                    unique case (s_q.ptr)
                        `ASIR_OFS_X_HIGH: s_d.ptr = fast_read ? `ASIR_OFS_Y_HIGH
                                                              : `ASIR_OFS_X_LOW;
                        `ASIR_OFS_Y_HIGH: s_d.ptr = fast_read ? `ASIR_OFS_Z_HIGH
                                                              : `ASIR_OFS_Y_LOW;
                        `ASIR_OFS_Z_HIGH: s_d.ptr = fast_read ? `ASIR_OFS_STATUS
                                                              : `ASIR_OFS_Z_LOW;
                        `ASIR_OFS_Z_LOW: s_d.ptr = `ASIR_OFS_STATUS;
                        default: s_d.ptr = s_q.ptr + 8'h01;
                    endcase
                    if (s_q.ptr == `ASIR_OFS_MODE) begin
                        s_d.cause[`ASIR_BIT_SLEEP_WAKE] = 1'b0;
                    end
                end
                default: begin
                    s_d.rdata = `ASIR_RST_BYTE;
                end
            endcase
        end
        // High reads clear each axis flag; a new sample overrides the clear
        s_d.dr = s_q.dr & ~hi_rd;
        s_d.ow = s_q.ow & ~hi_rd;
        if (sample_valid) begin
            s_d.xs = x_in;
            s_d.ys = y_in;
            s_d.zs = z_in;
            s_d.ow = s_d.ow | (s_q.dr & axis_en);
            s_d.dr = s_d.dr | axis_en;
        end
        // Source reads clear cause bits; a rise in the same cycle wins
        if (transient_source_rd) s_d.cause[`ASIR_BIT_TRANSIENT] = 1'b0;
        if (orientation_status_rd) s_d.cause[`ASIR_BIT_ORIENT] = 1'b0;
        if (tap_source_rd) s_d.cause[`ASIR_BIT_TAP] = 1'b0;
        if (fall_motion_source_rd) s_d.cause[`ASIR_BIT_FALL] = 1'b0;
        if (|hi_rd && !(|(s_d.dr & axis_en)) && !(|(s_d.ow & axis_en))) begin
            s_d.cause[`ASIR_BIT_READY] = 1'b0;
        end
        if (rise[4]) s_d.cause[`ASIR_BIT_TRANSIENT] = 1'b1;
        if (rise[3]) s_d.cause[`ASIR_BIT_ORIENT] = 1'b1;
        if (rise[2]) s_d.cause[`ASIR_BIT_TAP] = 1'b1;
        if (rise[1]) s_d.cause[`ASIR_BIT_FALL] = 1'b1;
        if (rise[0]) s_d.cause[`ASIR_BIT_READY] = 1'b1;
        // Mode machine; any event rise except data ready restarts the idle count
        unique case (s_q.mode)
            ASIR_STANDBY: begin
                s_d.idle_cnt = 8'h00;
                if (active) s_d.mode = ASIR_WAKE;
            end
            ASIR_WAKE: begin
                if (|rise[4:1]) begin
                    s_d.idle_cnt = 8'h00;
                end else if (to_sleep) begin
                    s_d.mode = ASIR_SLEEP;
                    s_d.idle_cnt = 8'h00;
                end else if (idle_tick && s_q.idle_cnt != 8'hFF) begin
                    s_d.idle_cnt = s_q.idle_cnt + 8'h01;
                end
            end
            ASIR_SLEEP: begin
                if (to_wake) s_d.mode = ASIR_WAKE;
            end
        endcase
        if (to_sleep || to_wake) s_d.cause[`ASIR_BIT_SLEEP_WAKE] = 1'b1;
        if (!active) s_d.mode = ASIR_STANDBY;
        s_d.cause[6] = 1'b0;
        s_d.cause[1] = 1'b0;
    end

    // System registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Mode code follows the enum order; standby is the reset value
    always_comb begin
        unique case (s_q.mode)
            ASIR_WAKE: operating_mode = `ASIR_MODE_WAKE;
            ASIR_SLEEP: operating_mode = `ASIR_MODE_SLEEP;
            default: operating_mode = `ASIR_MODE_STANDBY;
        endcase
    end
    assign low_rate_sel = (s_q.mode == ASIR_SLEEP);
    assign interrupt_cause = s_q.cause;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence x_high_taken;
        hi_read_x ##1 !req_edge [*2];
    endsequence

    sequence sleep_entry;
        to_sleep ##1 s_q.mode == ASIR_SLEEP;
    endsequence

    low_gate_a: assert property (do_read && (s_q.ptr == `ASIR_OFS_Y_LOW) && !s_q.low_ok
        |=> s_q.rdata == 8'h00) else $error("low byte read without high");
    low_pair_a: assert property (x_high_taken |-> s_q.held_low == $past(s_q.xs[3:0], 2))
        else $error("held low nibble lost");
    fast_skip_a: assert property (hi_read_x && fast_read
        |=> s_q.ptr == `ASIR_OFS_Y_HIGH) else $error("fast read did not skip");
    stop_ptr_a: assert property (req_edge && l_q.op == ASIR_OP_STOP
        |=> s_q.ptr == `ASIR_OFS_STATUS && !s_q.low_ok) else $error("stop kept pointer");
    sleep_flag_a: assert property (sleep_entry |-> s_q.cause[7] && low_rate_sel)
        else $error("sleep entry not flagged");
    mode_upper_a: assert property (do_read && s_q.ptr == `ASIR_OFS_MODE
        |=> s_q.rdata[7:2] == 6'h00 && !s_q.cause[7] || $past(to_sleep || to_wake))
        else $error("mode read wrong");
    ready_rise_a: assert property ($rose(lvl[0]) |=> s_q.cause[0])
        else $error("ready cause not set");
    ow_set_a: assert property (sample_valid && s_q.dr[0] && axis_en[0] && !hi_read_x
        |=> s_q.ow[0] && s_q.dr[0]) else $error("overwrite not flagged");
    reserved_a: assert property (s_q.cause[6] == 1'b0 && s_q.cause[1] == 1'b0)
        else $error("reserved cause bit set");
    link_answer_a: assert property (@(posedge link_clk) disable iff (link_rst)
        $rose(l_q.busy) |-> ##[1:20] !l_q.busy) else $error("link answer late");
endmodule // asir_regs

// ==== dv/asir_host_model.sv ====
// Host-side model of the serial protocol engine: load, read and stop strobes.
// Assumes the register bank answers each command within 20 link cycles.
`timescale 1ns/1ps
module asir_host_model (
    input wire logic link_clk, // Link clock
    input wire logic cmd_busy, // Bank still working on a command
    output logic cmd_load, // Load strobe
    output logic [7:0] cmd_addr, // Register address
    output logic cmd_read, // Read strobe
    output logic cmd_stop // Stop strobe
);
    // ****************************************
    // Command driver
    // ****************************************
    // Strobes idle low at time zero
    initial begin
        cmd_load = 1'b0;
        cmd_read = 1'b0;
        cmd_stop = 1'b0;
        cmd_addr = 8'hFF;
    end
    // Strobe is held for the one edge that takes it, then busy is waited out
    // so no second strobe lands while the bank would ignore it
    task automatic send(input logic [2:0] kind, input logic [7:0] addr);
        @(posedge link_clk);
        cmd_load <= kind[2];
        cmd_read <= kind[1];
        cmd_stop <= kind[0];
        cmd_addr <= addr;
        @(posedge link_clk);
        cmd_load <= 1'b0;
        cmd_read <= 1'b0;
        cmd_stop <= 1'b0;
        cmd_addr <= ~addr; // Released address must not linger
        // No cap here: a bank that never answers runs into the bench ceiling
        do begin
            @(posedge link_clk);
        end while (cmd_busy !== 1'b0);
    endtask
endmodule // asir_host_model

// ==== dv/accel_sample_and_irq_status_regs_bench.sv ====
// Self-checking bench for the sample, mode and interrupt cause registers.
// Assumes the host model in dv/ drives the link strobes.
`timescale 1ns/1ps
module accel_sample_and_irq_status_regs_bench;
    // ****************************************
    // Signals and clocks
    // ****************************************
    logic sys_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, link_rst = 1'b1;
    logic cmd_load, cmd_read, cmd_stop, cmd_busy, rd_valid;
    logic [7:0] cmd_addr, rd_data, idle_timeout_limit, interrupt_cause;
    logic sample_valid, fast_read, active, sleep_en, idle_tick, low_rate_sel;
    logic [11:0] x_in, y_in, z_in, xs, ys, zs, bx;
    logic [2:0] axis_en;
    logic [3:0] wake_sel, ev, srd;
    logic [4:0] int_en;
    logic [1:0] operating_mode;
    logic [31:0] seed = 32'hA863FC62;
    logic [7:0] exp_q[$];
    int err_total = 0, compares = 0, cyc = 0;
    // The 12 ns link clock never shares a rising edge with the 50 ns system clock
    always #25 sys_clk = ~sys_clk;
    always #6 link_clk = ~link_clk;
    asir_host_model u_asir_host_model (.link_clk(link_clk), .cmd_busy(cmd_busy),
        .cmd_load(cmd_load), .cmd_addr(cmd_addr), .cmd_read(cmd_read), .cmd_stop(cmd_stop));
    asir_regs u_asir_regs (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
        .link_rst(link_rst), .cmd_load(cmd_load), .cmd_addr(cmd_addr), .cmd_read(cmd_read),
        .cmd_stop(cmd_stop), .cmd_busy(cmd_busy), .rd_valid(rd_valid), .rd_data(rd_data),
        .sample_valid(sample_valid), .x_in(x_in), .y_in(y_in), .z_in(z_in),
        .axis_en(axis_en), .fast_read(fast_read), .active(active), .sleep_en(sleep_en),
        .idle_timeout_limit(idle_timeout_limit), .idle_tick(idle_tick),
        .wake_sel(wake_sel), .int_en(int_en), .transient_ea(ev[3]),
        .orientation_changed_flag(ev[2]), .tap_ea(ev[1]), .fall_ea(ev[0]),
        .transient_source_rd(srd[3]), .orientation_status_rd(srd[2]),
        .tap_source_rd(srd[1]), .fall_motion_source_rd(srd[0]),
        .operating_mode(operating_mode), .low_rate_sel(low_rate_sel),
        .interrupt_cause(interrupt_cause));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
            err_total++;
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic sys_wait(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic ld(input logic [7:0] a);
        u_asir_host_model.send(3'b100, a);
    endtask
    task automatic rd(input logic [7:0] exp);
        exp_q.push_back(exp);
        u_asir_host_model.send(3'b010, 8'h00);
    endtask
    task automatic stp();
        u_asir_host_model.send(3'b001, 8'h00);
    endtask
    // New random sample on all axes, one sys cycle pulse
    task automatic sample();
        seed = lfsr(seed);
        xs = seed[11:0];
        ys = seed[23:12];
        seed = lfsr(seed);
        zs = seed[11:0];
        @(posedge sys_clk);
        x_in <= xs;
        y_in <= ys;
        z_in <= zs;
        sample_valid <= 1'b1;
        @(posedge sys_clk);
        sample_valid <= 1'b0;
        sys_wait(6);
    endtask
    // Read answers are matched in order against the noted expectations
    always @(posedge link_clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0)
                chk("queued reads", 8'h00, 8'h01);
            else
                chk("rd_data", rd_data, exp_q.pop_front());
        end
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        int i;
        {sample_valid, fast_read, active, sleep_en, idle_tick} = 5'h00;
        {x_in, y_in, z_in} = 36'h0;
        {axis_en, wake_sel, ev, srd, int_en} = 20'h0;
        idle_timeout_limit = 8'h00;
        sys_wait(4);
        rst <= 1'b0;
        sys_wait(3);
        @(posedge link_clk);
        link_rst <= 1'b0;
        ld(8'h0B);
        rd(8'h00);
        rd(8'h00);
        stp();
        chk("operating_mode", {6'h00, operating_mode}, 8'h00);
        // Wake, then sleep on the tick that finds the count at its limit
        @(posedge sys_clk);
        active <= 1'b1;
        sleep_en <= 1'b1;
        idle_timeout_limit <= 8'h03;
        wake_sel <= 4'h1;
        sys_wait(3);
        for (i = 0; i < 4; i++) begin
            chk("operating_mode", {6'h00, operating_mode}, 8'h01);
            @(posedge sys_clk);
            idle_tick <= 1'b1;
            @(posedge sys_clk);
            idle_tick <= 1'b0;
            sys_wait(2);
        end
        chk("operating_mode", {6'h00, operating_mode}, 8'h02);
        chk("low_rate_sel", {7'h00, low_rate_sel}, 8'h01);
        chk("interrupt_cause", interrupt_cause, 8'h80);
        ld(8'h0B);
        rd(8'h02);
        stp();
        sys_wait(3);
        chk("interrupt_cause", interrupt_cause, 8'h00);
        // A selected, enabled event wakes the device and flags its own cause too
        @(posedge sys_clk);
        int_en <= 5'h02;
        ev[0] <= 1'b1;
        sys_wait(3);
        chk("operating_mode", {6'h00, operating_mode}, 8'h01);
        chk("low_rate_sel", {7'h00, low_rate_sel}, 8'h00);
        chk("interrupt_cause", interrupt_cause, 8'h84);
        ev[0] <= 1'b0;
        int_en <= 5'h00;
        srd[0] <= 1'b1;
        ld(8'h0B);
        rd(8'h01);
        stp();
        sys_wait(3);
        srd[0] <= 1'b0;
        chk("interrupt_cause", interrupt_cause, 8'h00);
        // Each function: masked, set on rise, cleared by its own source read
        for (i = 0; i < 4; i++) begin
            ev[i] <= 1'b1;
            sys_wait(3);
            chk("interrupt_cause", interrupt_cause, 8'h00);
            ev[i] <= 1'b0;
            sys_wait(2);
            int_en[i + 1] <= 1'b1;
            ev[i] <= 1'b1;
            sys_wait(3);
            chk("interrupt_cause", interrupt_cause, 8'h04 << i);
            srd[i] <= 1'b1;
            @(posedge sys_clk);
            srd[i] <= 1'b0;
            sys_wait(3);
            chk("interrupt_cause", interrupt_cause, 8'h00);
            ev[i] <= 1'b0;
        end
        // Two samples unread: overwrite on all axes, data-ready cause set
        int_en <= 5'h01;
        axis_en <= 3'h7;
        sample();
        sample();
        bx = xs;
        chk("interrupt_cause", interrupt_cause, 8'h01);
        ld(8'h00);
        rd(8'hFF);
        sys_wait(3);
        chk("interrupt_cause", interrupt_cause, 8'h01);
        rd(bx[11:4]);
        sample();
        rd({bx[3:0], 4'h0});
        rd(ys[11:4]);
        rd({ys[3:0], 4'h0});
        rd(zs[11:4]);
        rd({zs[3:0], 4'h0});
        rd(8'h09);
        stp();
        // Fast read skips the low bytes, then all high reads clear ready
        @(posedge sys_clk);
        fast_read <= 1'b1;
        ld(8'h01);
        rd(xs[11:4]);
        rd(ys[11:4]);
        rd(zs[11:4]);
        rd(8'h00);
        stp();
        sys_wait(3);
        chk("interrupt_cause", interrupt_cause, 8'h00);
        fast_read <= 1'b0;
        // Direct low-byte read and an unmapped address both read zero
        ld(8'h04);
        rd(8'h00);
        stp();
        ld(8'h20);
        rd(8'h00);
        stp();
        @(posedge sys_clk);
        active <= 1'b0;
        sys_wait(3);
        chk("operating_mode", {6'h00, operating_mode}, 8'h00);
        chk("pending reads", 8'(exp_q.size()), 8'h00);
        give_verdict();
    end
endmodule // accel_sample_and_irq_status_regs_bench
